// ==== rtl/pmpr_ctrl.v ====
/*
 * Port match detector and pin router control register with the pin
 * driver and weak pullup gating that the register steers.
 * Assumes a special-function register port on clk_sys, port pins that
 * arrive asynchronously, and a routing matrix outside that supplies the
 * per-pin drive request, drive value and output mode.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pmpr_consts.vh"

module pmpr_ctrl #(
    parameter NPORT_BITS = 32
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_page,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    input wire [NPORT_BITS-1:0] port_pin_in,
    input wire [NPORT_BITS-1:0] port_digital_in_mode,
    input wire [NPORT_BITS-1:0] port_push_pull_mode,
    input wire [NPORT_BITS-1:0] route_drive_req,
    input wire [NPORT_BITS-1:0] route_drive_val,
    output reg [NPORT_BITS-1:0] port_pin_out,
    output reg [NPORT_BITS-1:0] port_pin_oe,
    output reg [NPORT_BITS-1:0] port_pullup_en,
    output wire pin_router_enable,
    output wire lin_pin_route_enable,
    output wire weak_pullup_disable,
    output wire port_mismatch_irq,
    output wire port_mismatch_wake
);

    // Masked compare of one 8-bit port
    function port_differs;
        input [7:0] pins;
        input [7:0] expect_val;
        input [7:0] mask;
        begin
            port_differs = ((pins & mask) != (expect_val & mask));
        end
    endfunction

    reg [7:0] pin_router_control_c_q;
    reg [7:0] port0_expected_value_q;
    reg [7:0] port1_expected_value_q;
    reg [7:0] port2_expected_value_q;
    reg [7:0] port3_expected_value_q;
    reg [7:0] port0_compare_mask_q;
    reg [7:0] port1_compare_mask_q;
    reg [7:0] port2_compare_mask_q;
    reg [7:0] port3_compare_mask_q;
    reg mismatch_q;
    reg mismatch_d;
    reg [7:0] rdata_d;
    reg [NPORT_BITS-1:0] oe_d;
    reg [NPORT_BITS-1:0] pullup_d;
    wire [NPORT_BITS-1:0] pins_sync;
    wire [NPORT_BITS-1:0] mode_sync;
    wire page_router;
    wire page_match;

    // Pins and the analog/digital mode both come from outside the clock
    pmpr_sync #(
        .WIDTH(NPORT_BITS),
        .RST_VAL({NPORT_BITS{1'b1}})
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(port_pin_in),
        .sync_out(pins_sync)
    );

    pmpr_sync #(
        .WIDTH(NPORT_BITS),
        .RST_VAL({NPORT_BITS{1'b1}})
    ) u_mode_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(port_digital_in_mode),
        .sync_out(mode_sync)
    );

    assign page_router = (sfr_page == `PMPR_PAGE_ROUTER);
    assign page_match = (sfr_page == `PMPR_PAGE_MATCH);

    // Register writes
    always @(posedge clk_sys) begin
        if (rst) begin
            pin_router_control_c_q <= `PMPR_RST_ROUTER_C;
            port0_expected_value_q <= `PMPR_RST_EXPECT;
            port1_expected_value_q <= `PMPR_RST_EXPECT;
            port2_expected_value_q <= `PMPR_RST_EXPECT;
            port3_expected_value_q <= `PMPR_RST_EXPECT;
            port0_compare_mask_q <= `PMPR_RST_MASK;
            port1_compare_mask_q <= `PMPR_RST_MASK;
            port2_compare_mask_q <= `PMPR_RST_MASK;
            port3_compare_mask_q <= `PMPR_RST_MASK;
        end else if (sfr_wr) begin
            if (page_router && sfr_addr == `PMPR_ADDR_ROUTER_C) begin
                // Read-only bit 2 keeps its zero
                pin_router_control_c_q <= sfr_wdata & `PMPR_ROUTER_WR_MASK;
            end
            if (page_match) begin
                case (sfr_addr)
                    `PMPR_ADDR_P0_EXPECT: begin
                        port0_expected_value_q <= sfr_wdata;
                    end
                    `PMPR_ADDR_P0_MASK: begin
                        port0_compare_mask_q <= sfr_wdata;
                    end
                    `PMPR_ADDR_P1_EXPECT: begin
                        port1_expected_value_q <= sfr_wdata;
                    end
                    `PMPR_ADDR_P1_MASK: begin
                        port1_compare_mask_q <= sfr_wdata;
                    end
                    `PMPR_ADDR_P2_EXPECT: begin
                        port2_expected_value_q <= sfr_wdata;
                    end
                    `PMPR_ADDR_P2_MASK: begin
                        port2_compare_mask_q <= sfr_wdata;
                    end
                    `PMPR_ADDR_P3_EXPECT: begin
                        port3_expected_value_q <= sfr_wdata;
                    end
                    `PMPR_ADDR_P3_MASK: begin
                        port3_compare_mask_q <= sfr_wdata;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_d = 8'h00;
        if (page_router && sfr_addr == `PMPR_ADDR_ROUTER_C) begin
            rdata_d = pin_router_control_c_q;
        end else if (page_match) begin
            case (sfr_addr)
                `PMPR_ADDR_P0_EXPECT: rdata_d = port0_expected_value_q;
                `PMPR_ADDR_P0_MASK: rdata_d = port0_compare_mask_q;
                `PMPR_ADDR_P1_EXPECT: rdata_d = port1_expected_value_q;
                `PMPR_ADDR_P1_MASK: rdata_d = port1_compare_mask_q;
                `PMPR_ADDR_P2_EXPECT: rdata_d = port2_expected_value_q;
                `PMPR_ADDR_P2_MASK: rdata_d = port2_compare_mask_q;
                `PMPR_ADDR_P3_EXPECT: rdata_d = port3_expected_value_q;
                `PMPR_ADDR_P3_MASK: rdata_d = port3_compare_mask_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_d;
        end
    end

    assign weak_pullup_disable = pin_router_control_c_q[`PMPR_BIT_WEAK_PULLUP_DISABLE];
    assign pin_router_enable = pin_router_control_c_q[`PMPR_BIT_PIN_ROUTER_ENABLE];
    // LIN signals reach pins only through an enabled matrix
    assign lin_pin_route_enable = pin_router_enable &
        pin_router_control_c_q[`PMPR_BIT_LIN_PIN_ROUTE_ENABLE];

    // Pin drivers and weak pullups
    always @* begin
        // Open-drain drives only a low; push-pull drives both levels
        oe_d = route_drive_req & mode_sync &
            (port_push_pull_mode | ~route_drive_val);
        if (!pin_router_enable) begin
            oe_d = {NPORT_BITS{1'b0}};
        end
        // Pullup on digital open-drain pins not pulling low
        pullup_d = mode_sync & ~port_push_pull_mode & ~oe_d;
        if (weak_pullup_disable) begin
            pullup_d = {NPORT_BITS{1'b0}};
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            port_pin_out <= {NPORT_BITS{1'b0}};
            port_pin_oe <= {NPORT_BITS{1'b0}};
            port_pullup_en <= {NPORT_BITS{1'b0}};
        end else begin
            port_pin_out <= route_drive_val & oe_d;
            port_pin_oe <= oe_d;
            port_pullup_en <= pullup_d;
        end
    end

    // Raw synchronised pins regardless of routing
    always @* begin
        mismatch_d = port_differs(pins_sync[7:0], port0_expected_value_q,
                port0_compare_mask_q) |
            port_differs(pins_sync[15:8], port1_expected_value_q,
                port1_compare_mask_q) |
            port_differs(pins_sync[23:16], port2_expected_value_q,
                port2_compare_mask_q) |
            port_differs(pins_sync[31:24], port3_expected_value_q,
                port3_compare_mask_q);
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= mismatch_d;
        end
    end

    assign port_mismatch_irq = mismatch_q;
    assign port_mismatch_wake = mismatch_q;

endmodule // pmpr_ctrl

`default_nettype wire

// ==== inc/pmpr_consts.vh ====
/*
 * Register map, field positions and reset values of the port match
 * and pin router control block.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef PMPR_CONSTS_VH
`define PMPR_CONSTS_VH

// Register pages
`define PMPR_PAGE_ROUTER 8'h0F
`define PMPR_PAGE_MATCH 8'h00

// Register addresses
`define PMPR_ADDR_ROUTER_C 8'hC7
`define PMPR_ADDR_P0_EXPECT 8'hF1
`define PMPR_ADDR_P0_MASK 8'hF2
`define PMPR_ADDR_P1_EXPECT 8'hF3
`define PMPR_ADDR_P1_MASK 8'hF4
`define PMPR_ADDR_P2_EXPECT 8'hB1
`define PMPR_ADDR_P2_MASK 8'hB2
`define PMPR_ADDR_P3_EXPECT 8'hAE
`define PMPR_ADDR_P3_MASK 8'hAF

// Router control field positions
`define PMPR_BIT_WEAK_PULLUP_DISABLE 7
`define PMPR_BIT_PIN_ROUTER_ENABLE 6
`define PMPR_BIT_LIN_PIN_ROUTE_ENABLE 0
// Bits that software may write; bit 2 is read-only and reads zero
`define PMPR_ROUTER_WR_MASK 8'hFB

// Reset values
`define PMPR_RST_ROUTER_C 8'h00
`define PMPR_RST_EXPECT 8'hFF
`define PMPR_RST_MASK 8'h00

`endif

// ==== rtl/pmpr_sync.v ====
/*
 * Two-stage synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slow level; no word coherence is promised.
 */
`timescale 1ns/10ps
`default_nettype none

module pmpr_sync #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    input wire clk_sys,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // pmpr_sync

`default_nettype wire

// ==== tb/pmpr_ctrl_sva.sv ====
/* Assertion checker for pmpr_ctrl, bound to its ports.
   Assumes clk_sys with a synchronous active-high rst. */
`timescale 1ns/10ps
`default_nettype none
module pmpr_ctrl_chk #(parameter NPORT_BITS = 32) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [NPORT_BITS-1:0] port_pin_in,
    input wire logic [NPORT_BITS-1:0] port_push_pull_mode,
    input wire logic [NPORT_BITS-1:0] route_drive_req,
    input wire logic [NPORT_BITS-1:0] port_pin_out,
    input wire logic [NPORT_BITS-1:0] port_pin_oe,
    input wire logic [NPORT_BITS-1:0] port_pullup_en,
    input wire logic pin_router_enable,
    input wire logic lin_pin_route_enable,
    input wire logic weak_pullup_disable,
    input wire logic port_mismatch_irq,
    input wire logic port_mismatch_wake
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire rt_hit = sfr_page == 8'h0F && sfr_addr == 8'hC7;
    lin_router_a: assert property (lin_pin_route_enable |-> pin_router_enable)
        else $error("lin route on while router off");
    lin_wr_a: assert property (sfr_wr && rt_hit |=>
        lin_pin_route_enable == ($past(sfr_wdata[6]) && $past(sfr_wdata[0])))
        else $error("lin route bit not applied");
    router_off_a: assert property (!pin_router_enable |=> port_pin_oe == '0)
        else $error("driver enabled while router off");
    out_no_oe_a: assert property ((port_pin_out & ~port_pin_oe) == '0)
        else $error("output data on undriven pin");
    router_wr_a: assert property (sfr_wr && rt_hit |=>
        {weak_pullup_disable, pin_router_enable} == $past(sfr_wdata[7:6]))
        else $error("router bits not written");
    pullup_off_a: assert property (weak_pullup_disable |=> port_pullup_en == '0)
        else $error("pullup on while disabled");
    pullup_drive_a: assert property ((port_pullup_en & port_pin_oe) == '0)
        else $error("pullup on a driven pin");
    pullup_pp_a: assert property ((port_pullup_en & $past(port_push_pull_mode)) == '0)
        else $error("pullup on push-pull pin");
    oe_req_a: assert property ((port_pin_oe & ~$past(route_drive_req)) == '0)
        else $error("driver without request");
    rd_bit2_a: assert property (sfr_rd && rt_hit |=> sfr_rdata[2] == 1'b0)
        else $error("read-only router bit set");
    irq_wake_a: assert property (port_mismatch_irq == port_mismatch_wake)
        else $error("wake differs from irq");
    irq_steady_a: assert property ((!sfr_wr && $stable(port_pin_in))[*4] |=>
        $stable(port_mismatch_irq))
        else $error("mismatch moved without cause");
    cover property (port_mismatch_irq);
    cover property (sfr_wr && rt_hit);
    cover property (|port_pin_oe);
endmodule // pmpr_ctrl_chk
bind pmpr_ctrl pmpr_ctrl_chk #(.NPORT_BITS(NPORT_BITS)) i_chk (.clk_sys, .rst, .sfr_addr,
    .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .port_pin_in, .port_push_pull_mode,
    .route_drive_req, .port_pin_out, .port_pin_oe, .port_pullup_en, .pin_router_enable,
    .lin_pin_route_enable, .weak_pullup_disable, .port_mismatch_irq, .port_mismatch_wake);
`default_nettype wire

// ==== tb/pmpr_pin_model.sv ====
/* Far-side pin model: resolves each pin from block drive, pullup and an
   external driver. Assumes the bench sets ext_* off the clock edge. */
`timescale 1ns/10ps
`default_nettype none
module pmpr_pin_model (
    input wire logic clk_sys,
    input wire logic [31:0] ext_drive,
    input wire logic [31:0] ext_level,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pullup_en,
    output logic [31:0] pin_level
);
    logic [31:0] float_q = 32'h5555_5555;
    // Undriven pins with no pullup wander every cycle
    always @(posedge clk_sys) float_q <= ~float_q;
    always_comb pin_level = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level)
        | (~pin_oe & ~ext_drive & (pullup_en | float_q));
endmodule // pmpr_pin_model
`default_nettype wire

// ==== tb/tb_top.sv ====
/* Self-checking bench for pmpr_ctrl with the pin model on its pins.
   Assumes a 20 MHz clk_sys and synchronous active-high rst. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_sys = 0, rst = 1, sfr_wr = 0, sfr_rd = 0;
    logic [7:0] sfr_addr = 0, sfr_page = 0, sfr_wdata = 0;
    logic [31:0] dig = '1, pp = '0, req = '0, val = '0, ext_lvl = '1;
    wire [7:0] sfr_rdata;
    wire [31:0] pins, p_out, p_oe, p_pu;
    wire rt_en, lin_en, wpd, irq, wake;
    int n_fail = 0, compares = 0, cyc = 0;
    logic [7:0] maddr [4] = '{8'hF2, 8'hF4, 8'hB2, 8'hAF};
    logic [7:0] eaddr [4] = '{8'hF1, 8'hF3, 8'hB1, 8'hAE};
    pmpr_ctrl i_dut (.clk_sys, .rst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .port_pin_in(pins), .port_digital_in_mode(dig), .port_push_pull_mode(pp),
        .route_drive_req(req), .route_drive_val(val), .port_pin_out(p_out), .port_pin_oe(p_oe),
        .port_pullup_en(p_pu), .pin_router_enable(rt_en), .lin_pin_route_enable(lin_en),
        .weak_pullup_disable(wpd), .port_mismatch_irq(irq), .port_mismatch_wake(wake));
    pmpr_pin_model i_pins (.clk_sys, .ext_drive(32'hFFFF_FFFF), .ext_level(ext_lvl),
        .pin_out(p_out), .pin_oe(p_oe), .pullup_en(p_pu), .pin_level(pins));
    always #25 clk_sys = ~clk_sys;
    task automatic final_report;
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
        {sfr_page, sfr_addr, sfr_wdata, sfr_wr} = {pg, ad, d, 1'b1};
        tick(1);
        sfr_wr = 0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp);
        {sfr_page, sfr_addr, sfr_rd} = {pg, ad, 1'b1};
        tick(1);
        sfr_rd = 0;
        chk(sfr_rdata, exp);
        tick(1);
    endtask
    initial begin
        tick(10);
        rst = 0;
        for (int i = 0; i < 4; i++) begin
            rd(8'h00, maddr[i], 8'h00);
            rd(8'h00, eaddr[i], 8'hFF);
        end
        rd(8'h0F, 8'hC7, 8'h00);
        chk({rt_en, lin_en, wpd, irq}, 0);
        wr(8'h0F, 8'hC7, 8'hC1);
        rd(8'h0F, 8'hC7, 8'hC1);
        chk({rt_en, lin_en, wpd}, 3'b111);
        wr(8'h0F, 8'hC7, 8'h01);
        chk({rt_en, lin_en, wpd}, 3'b000);
        wr(8'h00, 8'hC7, 8'h40);
        rd(8'h0F, 8'hC7, 8'h01);
        rd(8'h00, 8'h00, 8'h00);
        wr(8'h0F, 8'hC7, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, maddr[i], 8'h80);
            ext_lvl[8*i+6] = 0;
            tick(4);
            chk(irq, 0);
            ext_lvl[8*i+7] = 0;
            tick(4);
            chk({irq, wake}, 2'b11);
            wr(8'h00, eaddr[i], 8'h7F);
            tick(1);
            chk(irq, 0);
            wr(8'h00, maddr[i], 8'h00);
            wr(8'h00, eaddr[i], 8'hFF);
            ext_lvl = '1;
        end
        wr(8'h0F, 8'hC7, 8'h00);
        {req, val, pp, dig} = {32'h0000_00FF, 32'h0000_000F, 32'h0000_0033, 32'hFFFF_FFFB};
        tick(4);
        chk(p_oe, 0);
        chk(p_pu, 32'hFFFF_FFC8);
        wr(8'h0F, 8'hC7, 8'h40);
        tick(1);
        chk(p_oe, 32'h0000_00F3);
        chk(p_out, 32'h0000_0003);
        chk(p_pu, 32'hFFFF_FF08);
        wr(8'h0F, 8'hC7, 8'hC0);
        tick(1);
        chk(p_pu, 0);
        final_report;
    end
endmodule // tb_top
`default_nettype wire
